/* File: verilog/dil_regs.svh */
// constants of the converter input latch and sleep sequencer
`ifndef DIL_REGS_SVH
`define DIL_REGS_SVH

`define DIL_WIDTH          14
`define DIL_MSB            13
`define DIL_MODE_BINARY    1'b0
`define DIL_MODE_TWOS      1'b1
`define DIL_CLK_PERIOD_NS  50
`define DIL_PDN_TIME_NS    5000
`define DIL_PUP_TIME_NS    3000000
// longest time rounds down, least time rounds up
`define DIL_PDN_CYCLES     (`DIL_PDN_TIME_NS / `DIL_CLK_PERIOD_NS)
`define DIL_PUP_CYCLES     ((`DIL_PUP_TIME_NS + `DIL_CLK_PERIOD_NS - 1) / `DIL_CLK_PERIOD_NS)

`endif

/* File: verilog/dil_pkg.sv */
// types shared by the converter input latch and sleep sequencer
package dil_pkg;

    typedef enum logic [1:0] {
        DIL_ACTIVE   = 2'b00,
        DIL_PWR_DOWN = 2'b01,
        DIL_ASLEEP   = 2'b10,
        DIL_PWR_UP   = 2'b11
    } dil_state_type;

    typedef struct packed {
        logic [13:0] primary;
        logic [13:0] complementary;
    } dil_pair_type;

endpackage

/* File: verilog/dil_sleep_seq.sv */
// sleep power-down and power-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dil_regs.svh"

module dil_sleep_seq #(
    parameter int PDN_CYCLES = `DIL_PDN_CYCLES,
    parameter int PUP_CYCLES = `DIL_PUP_CYCLES
) (
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire logic               clk_en,
    input  wire logic               sleep_sync,
    output var dil_pkg::dil_state_type state,
    output logic                    analog_on
);

    localparam int CW = $clog2(PUP_CYCLES + PDN_CYCLES + 1);

    dil_pkg::dil_state_type state_q;
    dil_pkg::dil_state_type state_d;
    logic [CW-1:0]          cnt_q;

    // ---------------------------------------------------------------
    // state machine
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            dil_pkg::DIL_ACTIVE: begin
                if (sleep_sync) state_d = dil_pkg::DIL_PWR_DOWN;
            end
            dil_pkg::DIL_PWR_DOWN: begin
                // finishes even if sleep drops: a half-off array is unsafe
                if (cnt_q == CW'(PDN_CYCLES - 1)) state_d = dil_pkg::DIL_ASLEEP;
            end
            dil_pkg::DIL_ASLEEP: begin
                if (!sleep_sync) state_d = dil_pkg::DIL_PWR_UP;
            end
            default: begin
                if (sleep_sync) begin
                    state_d = dil_pkg::DIL_PWR_DOWN;
                end else if (cnt_q == CW'(PUP_CYCLES - 1)) begin
                    state_d = dil_pkg::DIL_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q <= dil_pkg::DIL_ACTIVE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (state_d != state_q) cnt_q <= '0;
            else                    cnt_q <= cnt_q + CW'(1);
        end
    end

    assign state     = state_q;
    assign analog_on = (state_q == dil_pkg::DIL_ACTIVE);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_pup_length;
        @(posedge mclk) disable iff (!reset_n)
        $rose(state_q == dil_pkg::DIL_ACTIVE) |->
            $past(state_q) == dil_pkg::DIL_PWR_UP &&
            $past(cnt_q) == CW'(PUP_CYCLES - 1);
    endproperty
    a_pup_length: assert property (p_pup_length)
        else $error("left power-up before its full count");

    property p_pdn_length;
        @(posedge mclk) disable iff (!reset_n)
        state_q == dil_pkg::DIL_PWR_DOWN |-> cnt_q < CW'(PDN_CYCLES);
    endproperty
    a_pdn_length: assert property (p_pdn_length)
        else $error("power-down ran past its limit");

    c_full_cycle: cover property (@(posedge mclk) disable iff (!reset_n)
        $rose(state_q == dil_pkg::DIL_ACTIVE)
        && $past(state_q) == dil_pkg::DIL_PWR_UP);

endmodule
`default_nettype wire

/* File: verilog/dil_top.sv */
// input latch, format conversion and sleep control of the converter
`timescale 1ns/1ps
`default_nettype none
`include "dil_regs.svh"

// Summary of operation
// - word captured on each rising clock edge with clk_en high while powered up
// - word is 14 bits, bit 13 most significant
// - primary output full scale at all ones in binary coding
// - complementary output full scale at all zeros in binary coding
// - coding straight binary or twos complement
// - mode defaults to zero when left low
// - sleep asynchronous, active high, powers down
// - power down within 5 us, up 3 ms
module dil_top #(
    parameter int WIDTH      = `DIL_WIDTH,
    parameter int PDN_CYCLES = `DIL_PDN_CYCLES,
    parameter int PUP_CYCLES = `DIL_PUP_CYCLES
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] sample_in,
    input  wire logic             mode_sel,
    input  wire logic             sleep,
    output logic      [WIDTH-1:0] primary_current_out,
    output logic      [WIDTH-1:0] complementary_current_out,
    output logic                  output_valid,
    output logic                  powered_down
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic sleep_s1_q;
    logic sleep_s2_q;
    logic mode_s1_q;
    logic mode_s2_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
        end else if (clk_en) begin
            sleep_s1_q <= sleep;
            sleep_s2_q <= sleep_s1_q;
        end
    end

    // the pin has a pulldown, so an idle pin resets to binary coding
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode_s1_q <= `DIL_MODE_BINARY;
            mode_s2_q <= `DIL_MODE_BINARY;
        end else if (clk_en) begin
            mode_s1_q <= mode_sel;
            mode_s2_q <= mode_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // sleep sequencer
    // ---------------------------------------------------------------
    dil_pkg::dil_state_type state;
    logic                   analog_on;

    dil_sleep_seq #(
        .PDN_CYCLES (PDN_CYCLES),
        .PUP_CYCLES (PUP_CYCLES)
    ) u_seq (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .sleep_sync (sleep_s2_q),
        .state      (state),
        .analog_on  (analog_on)
    );

    // the raw pin is or-ed in so power-down shows even with no clock;
    // the sequencer still waits for the synchronised copy
    assign powered_down = sleep | ~analog_on;
    assign output_valid = analog_on;

    // ---------------------------------------------------------------
    // format conversion
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] conv_code;
    logic [WIDTH-1:0] comp_code;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            if (gi == `DIL_MSB) begin : g_msb
                // twos complement becomes offset binary
                assign conv_code[gi] = sample_in[gi] ^ mode_s2_q;
            end else begin : g_lsb
                assign conv_code[gi] = sample_in[gi];
            end
            assign comp_code[gi] = ~conv_code[gi];
        end
    endgenerate

    // ---------------------------------------------------------------
    // input latch
    // ---------------------------------------------------------------
    dil_pkg::dil_pair_type pair_q;

    // one word per edge with no buffer: a faster source loses words
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pair_q <= '0;
        end else if (clk_en) begin
            if (analog_on) begin
                pair_q.primary       <= conv_code;
                pair_q.complementary <= comp_code;
            end else begin
                // switched off array sources no current on either side
                pair_q <= '0;
            end
        end
    end

    assign primary_current_out       = pair_q.primary;
    assign complementary_current_out = pair_q.complementary;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    localparam logic [WIDTH-1:0] ONES    = '1;
    localparam logic [WIDTH-1:0] MAX_POS = ONES >> 1;

    property p_capture;
        @(posedge mclk) disable iff (!reset_n)
        clk_en && analog_on |=> primary_current_out == $past(conv_code);
    endproperty
    a_capture: assert property (p_capture)
        else $error("latched word does not match captured input");

    property p_lsb_pass;
        @(posedge mclk) disable iff (!reset_n)
        clk_en && analog_on |=>
            primary_current_out[`DIL_MSB-1:0] ==
            $past(sample_in[`DIL_MSB-1:0]);
    endproperty
    a_lsb_pass: assert property (p_lsb_pass)
        else $error("low bits altered by conversion");

    property p_full_scale;
        @(posedge mclk) disable iff (!reset_n)
        clk_en && analog_on && mode_s2_q == `DIL_MODE_BINARY
            && sample_in == ONES |=> primary_current_out == ONES;
    endproperty
    a_full_scale: assert property (p_full_scale)
        else $error("all ones did not give full scale");

    property p_differential;
        @(posedge mclk) disable iff (!reset_n)
        clk_en && analog_on |=>
            (primary_current_out ^ complementary_current_out) == ONES;
    endproperty
    a_differential: assert property (p_differential)
        else $error("outputs are not complementary");

    property p_twos_max;
        @(posedge mclk) disable iff (!reset_n)
        clk_en && analog_on && mode_s2_q == `DIL_MODE_TWOS
            && sample_in == MAX_POS |=> primary_current_out == ONES;
    endproperty
    a_twos_max: assert property (p_twos_max)
        else $error("largest twos complement word not full scale");

    property p_msb_flip;
        @(posedge mclk) disable iff (!reset_n)
        clk_en && analog_on |=>
            primary_current_out[`DIL_MSB] ==
            ($past(sample_in[`DIL_MSB]) ^ $past(mode_s2_q));
    endproperty
    a_msb_flip: assert property (p_msb_flip)
        else $error("msb not handled per coding mode");

    property p_mode_default;
        @(posedge mclk) disable iff (!reset_n)
        $rose(reset_n) |-> mode_s2_q == `DIL_MODE_BINARY;
    endproperty
    a_mode_default: assert property (p_mode_default)
        else $error("mode not binary after reset");

    property p_sleep_async;
        @(posedge mclk) disable iff (!reset_n)
        sleep |-> powered_down;
    endproperty
    a_sleep_async: assert property (p_sleep_async)
        else $error("sleep high but not shown powered down");

    property p_sleep_stop;
        @(posedge mclk) disable iff (!reset_n)
        clk_en && sleep_s2_q && analog_on |=> !analog_on ##1
            (!$past(clk_en) || (primary_current_out == '0
            && complementary_current_out == '0));
    endproperty
    a_sleep_stop: assert property (p_sleep_stop)
        else $error("converter not stopped after sleep");

    c_binary: cover property (@(posedge mclk) disable iff (!reset_n)
        clk_en && analog_on && mode_s2_q == `DIL_MODE_BINARY);
    c_twos: cover property (@(posedge mclk) disable iff (!reset_n)
        clk_en && analog_on && mode_s2_q == `DIL_MODE_TWOS);
    c_sleep: cover property (@(posedge mclk) disable iff (!reset_n)
        state == dil_pkg::DIL_ASLEEP);

endmodule
`default_nettype wire

/* File: tb/dil_drv_model.sv */
// sample word driver standing in for the signal processor
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------
// driver model
// -------------------------------------------------
module dil_drv_model (
    input  wire logic        mclk,
    input  wire logic        send,
    input  wire logic [13:0] word,
    output logic      [13:0] sample_in
);
    logic [13:0] drive_q = 14'h2a55;

    // at most one new word per edge, all 14 bits at once
    always_ff @(posedge mclk) begin
        if (send) begin
            drive_q <= word;
        end else begin
            // idle bus toggles so stale data never passes for a word
            drive_q <= ~drive_q;
        end
    end

    assign sample_in = drive_q;
endmodule
`default_nettype wire

/* File: tb/dil_top_tb.sv */
// self-checking bench of the converter input latch and sleep control
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------
// bench top
// -------------------------------------------------
module dil_top_tb;
    localparam int PDN = 4;
    localparam int PUP = 20;

    typedef struct packed {
        logic        mode;
        logic [13:0] w;
        logic [13:0] p;
    } dil_row_type;

    logic        mclk;
    logic        reset_n;
    logic        clk_en;
    logic        mode_sel;
    logic        sleep;
    logic        send;
    logic [13:0] word;
    logic [13:0] sample_in;
    logic [13:0] pri;
    logic [13:0] cmp;
    logic        output_valid;
    logic        powered_down;
    int          errors;
    int          n_tests;
    int          n;
    dil_row_type rows [10];

    dil_drv_model drv (
        .mclk      (mclk),
        .send      (send),
        .word      (word),
        .sample_in (sample_in)
    );

    dil_top #(.PDN_CYCLES(PDN), .PUP_CYCLES(PUP)) dut (
        .mclk                      (mclk),
        .reset_n                   (reset_n),
        .clk_en                    (clk_en),
        .sample_in                 (sample_in),
        .mode_sel                  (mode_sel),
        .sleep                     (sleep),
        .primary_current_out       (pri),
        .complementary_current_out (cmp),
        .output_valid              (output_valid),
        .powered_down              (powered_down)
    );

    always #25 mclk = ~mclk;

    // -------------------------------------------------
    // helpers
    // -------------------------------------------------
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // word reaches the model one edge later and the latch one more
    task automatic drive(input logic [13:0] w);
        @(posedge mclk);
        send <= 1'b1;
        word <= w;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask

    // -------------------------------------------------
    // sequence
    // -------------------------------------------------
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        mode_sel = 1'b0;
        sleep = 1'b0;
        send = 1'b0;
        word = 14'h0000;
        errors = 0;
        n_tests = 0;
        rows = '{'{1'b0, 14'h0000, 14'h0000}, '{1'b0, 14'h3fff, 14'h3fff},
                 '{1'b0, 14'h2000, 14'h2000}, '{1'b0, 14'h1fff, 14'h1fff},
                 '{1'b0, 14'h0001, 14'h0001}, '{1'b1, 14'h0000, 14'h2000},
                 '{1'b1, 14'h3fff, 14'h1fff}, '{1'b1, 14'h2000, 14'h0000},
                 '{1'b1, 14'h1fff, 14'h3fff}, '{1'b1, 14'h1234, 14'h3234}};
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check(pri, 14'h0000);
        check({13'h0000, output_valid}, 14'h0001);
        check({13'h0000, powered_down}, 14'h0000);
        @(posedge mclk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].mode !== mode_sel) begin
                @(posedge mclk);
                mode_sel <= rows[i].mode;
                repeat (3) @(posedge mclk);
            end
            drive(rows[i].w);
            check(pri, rows[i].p);
            check(cmp, ~rows[i].p);
        end
        // clock enable low must freeze the latch
        @(posedge mclk);
        clk_en <= 1'b0;
        drive(14'h0abc);
        check(pri, 14'h3234);
        @(posedge mclk);
        clk_en <= 1'b1;
        mode_sel <= 1'b0;
        repeat (3) @(posedge mclk);
        drive(14'h0abc);
        check(pri, 14'h0abc);
        // sleep: immediate flag, then sequenced power-down
        @(posedge mclk);
        sleep <= 1'b1;
        @(negedge mclk);
        check({13'h0000, powered_down}, 14'h0001);
        n = 0;
        while (output_valid !== 1'b0 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        check(n[13:0], 14'h0003);
        @(negedge mclk);
        check(pri, 14'h0000);
        check(cmp, 14'h0000);
        repeat (PDN + 10) @(posedge mclk);
        @(posedge mclk);
        sleep <= 1'b0;
        n = 0;
        while (output_valid !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
            check({13'h0000, powered_down}, {13'h0000, !output_valid});
        end
        check({13'h0000, (n >= PUP && n < PUP + 8)}, 14'h0001);
        drive(14'h1555);
        check(pri, 14'h1555);
        check(cmp, 14'h2aaa);
        // sleep again part way through power-up must restart power-down
        @(posedge mclk);
        sleep <= 1'b1;
        repeat (PDN + 10) @(posedge mclk);
        sleep <= 1'b0;
        repeat (8) @(posedge mclk);
        sleep <= 1'b1;
        repeat (PUP + 10) begin
            @(negedge mclk);
            check({13'h0000, output_valid}, 14'h0000);
        end
        @(posedge mclk);
        sleep <= 1'b0;
        n = 0;
        while (output_valid !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        check(n[13:0], 14'(PUP + 4));
        give_verdict;
    end

    initial begin
        #200000;
        errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
